/* File: src/nsx_pkg.sv */
/*
 * Package for the nibble swap, exclusive OR and direction load datapath.
 * Holds opcode enumeration, operand ranges, widths and reset values.
 * Assumes one clock domain and an asynchronous active-low reset.
 */
package nsx_pkg;
   localparam int          NSX_DATA_W      = 8;
   localparam int          NSX_ADDR_W      = 5;
   localparam int          NSX_NIB_W       = 4;
   localparam logic [4:0]  NSX_FILE_MAX    = 5'h1F;
   localparam logic [4:0]  NSX_DIR_SEL_LO  = 5'h06;
   localparam logic [4:0]  NSX_DIR_SEL_HI  = 5'h07;
   localparam logic        NSX_DEST_ACC    = 1'h0;
   localparam logic        NSX_DEST_FILE   = 1'h1;
   localparam logic [7:0]  NSX_ACC_RST     = 8'h00;
   localparam logic [7:0]  NSX_DIR_RST     = 8'hFF;
   localparam logic        NSX_ZERO_RST    = 1'h0;

   typedef enum logic [2:0] {
      NSX_OP_NONE,
      NSX_OP_NIBBLE_EXCHANGE_FILE,
      NSX_OP_EXCLUSIVE_OR_ACC_FILE,
      NSX_OP_EXCLUSIVE_OR_LITERAL,
      NSX_OP_DIR_LOAD
   } nsx_op_e;
endpackage

/* File: src/nsx_alu.sv */
/*
 * Combinational result former for the datapath.
 * Assumes the operation code and operands are stable within the cycle.
 */
`timescale 1ns/1ps
module nsx_alu
   import nsx_pkg::*;
(
   input  wire nsx_pkg::nsx_op_e i_op,      // Operation to perform
   input  wire logic [7:0]       i_acc,     // Accumulator value
   input  wire logic [7:0]       i_file,    // Addressed file register value
   input  wire logic [7:0]       i_lit,     // Immediate literal
   output logic      [7:0]       o_result,  // Operation result
   output logic                  o_is_zero  // Result equals zero
);
   wire logic [7:0] swapped;
   wire logic [7:0] xor_file;
   wire logic [7:0] xor_lit;

   assign swapped  = {i_file[NSX_NIB_W-1:0], i_file[NSX_DATA_W-1:NSX_NIB_W]};
   assign xor_file = i_acc ^ i_file;
   assign xor_lit  = i_acc ^ i_lit;

   assign o_result = (i_op == NSX_OP_NIBBLE_EXCHANGE_FILE)  ? swapped  :
                     (i_op == NSX_OP_EXCLUSIVE_OR_ACC_FILE) ? xor_file :
                     (i_op == NSX_OP_EXCLUSIVE_OR_LITERAL)  ? xor_lit  :
                     i_acc;
   assign o_is_zero = (o_result == 8'h00);
endmodule // nsx_alu

/* File: src/nsx_datapath.sv */
/*
 * Execution datapath for nibble exchange, exclusive OR with file or literal,
 * and loading the pin direction register from the accumulator.
 * Assumes the decoder presents one operation per cycle with i_valid, and the
 * file array returns the addressed register's value combinationally.
 */
`timescale 1ns/1ps
module nsx_datapath
   import nsx_pkg::*;
#(
   parameter int DATA_W = NSX_DATA_W,
   parameter int ADDR_W = NSX_ADDR_W
)(
   input  wire logic              i_clk,       // Core instruction clock
   input  wire logic              i_rstn,      // Asynchronous reset, active low
   input  wire logic              i_valid,     // Operation present this cycle
   input  wire nsx_pkg::nsx_op_e  i_op,        // Operation code
   input  wire logic [4:0]        i_faddr,     // File address operand
   input  wire logic              i_dest,      // Destination select bit
   input  wire logic [7:0]        i_lit,       // Immediate literal
   input  wire logic [7:0]        i_file_rd,   // Addressed file register value
   output logic      [7:0]        o_acc,       // Accumulator
   output logic                   o_zero,      // Zero status flag
   output logic                   o_file_we,   // File write strobe
   output logic      [4:0]        o_file_wa,   // File write address
   output logic      [7:0]        o_file_wd,   // File write data
   output logic      [7:0]        o_dir_a,     // Pin direction register, select 6
   output logic      [7:0]        o_dir_b      // Pin direction register, select 7
);
   // The ports and the result former are fixed at 8-bit data and a 5-bit file
   // address, so any other setting is refused while the design is elaborated.
   if (DATA_W != NSX_DATA_W || ADDR_W != NSX_ADDR_W) begin : g_bad_width
      $error("nsx_datapath supports only 8-bit data and 5-bit file address");
   end

   logic [7:0] acc_q, acc_d;
   logic       zero_q, zero_d;
   logic       fwe_q;
   logic [4:0] fwa_q;
   logic [7:0] fwd_q;
   logic [7:0] dira_q, dira_d;
   logic [7:0] dirb_q, dirb_d;

   wire logic [7:0] result;
   wire logic       res_zero;
   wire logic       is_file_op;
   wire logic       to_file;
   wire logic       to_acc;
   wire logic       dir_hit_a;
   wire logic       dir_hit_b;

   // One decode serves both direction registers, so a change in operand coding
   // stays in one place. Operands other than the two selects do nothing.
   function automatic logic dir_pick(input nsx_op_e    op,
                                     input logic [4:0] sel,
                                     input logic [4:0] want);
      return (op == NSX_OP_DIR_LOAD) && (sel == want);
   endfunction

   // The result former is shared by every operation; only the write enables
   // below decide where a result lands.
   nsx_alu u_alu (
      .i_op      (i_op),
      .i_acc     (acc_q),
      .i_file    (i_file_rd),
      .i_lit     (i_lit),
      .o_result  (result),
      .o_is_zero (res_zero)
   );

   assign is_file_op = (i_op == NSX_OP_NIBBLE_EXCHANGE_FILE) ||
                       (i_op == NSX_OP_EXCLUSIVE_OR_ACC_FILE);
   assign to_file    = i_valid && is_file_op && (i_dest == NSX_DEST_FILE);
   assign to_acc     = i_valid && ((is_file_op && (i_dest == NSX_DEST_ACC)) ||
                       (i_op == NSX_OP_EXCLUSIVE_OR_LITERAL));
   assign dir_hit_a  = i_valid && dir_pick(i_op, i_faddr, NSX_DIR_SEL_LO);
   assign dir_hit_b  = i_valid && dir_pick(i_op, i_faddr, NSX_DIR_SEL_HI);

   assign acc_d  = to_acc ? result : acc_q;
   assign dira_d = dir_hit_a ? acc_q : dira_q;
   assign dirb_d = dir_hit_b ? acc_q : dirb_q;
   // Only the file exclusive OR touches the flag; swap and direction load hold it.
   assign zero_d = (i_valid && i_op == NSX_OP_EXCLUSIVE_OR_ACC_FILE) ? res_zero : zero_q;

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         acc_q  <= NSX_ACC_RST;
         zero_q <= NSX_ZERO_RST;
         dira_q <= NSX_DIR_RST;
         dirb_q <= NSX_DIR_RST;
      end else begin
         acc_q  <= acc_d;
         zero_q <= zero_d;
         dira_q <= dira_d;
         dirb_q <= dirb_d;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         fwe_q <= 1'h0;
         fwa_q <= 5'h00;
         fwd_q <= 8'h00;
      end else begin
         fwe_q <= to_file;
         fwa_q <= i_faddr;
         fwd_q <= result;
      end
   end

   assign o_acc     = acc_q;
   assign o_zero    = zero_q;
   assign o_file_we = fwe_q;
   assign o_file_wa = fwa_q;
   assign o_file_wd = fwd_q;
   assign o_dir_a   = dira_q;
   assign o_dir_b   = dirb_q;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);

   // Held reset must show the documented idle values on every output but the file
   // write address and data. They are checked on the second low cycle; the asynchronous reset loads them as soon as i_rstn falls.
   reset_value_a: assert property (disable iff (1'b0)
      (!i_rstn ##1 !i_rstn) |-> o_acc == NSX_ACC_RST && o_zero == NSX_ZERO_RST
          && !o_file_we && o_dir_a == NSX_DIR_RST && o_dir_b == NSX_DIR_RST)
      else $error("outputs not at reset values");

   swap_result_a: assert property (
      (i_valid && i_op == NSX_OP_NIBBLE_EXCHANGE_FILE && i_dest == NSX_DEST_ACC)
      |=> o_acc == {$past(i_file_rd[3:0]), $past(i_file_rd[7:4])})
      else $error("nibble exchange result wrong");

   swap_to_file_a: assert property (
      (i_valid && i_op == NSX_OP_NIBBLE_EXCHANGE_FILE && i_dest == NSX_DEST_FILE)
      |=> o_file_we && o_file_wa == $past(i_faddr) && $stable(o_acc)
          && o_file_wd == {$past(i_file_rd[3:0]), $past(i_file_rd[7:4])})
      else $error("nibble exchange not written to file");

   xor_file_a: assert property (
      (i_valid && i_op == NSX_OP_EXCLUSIVE_OR_ACC_FILE && i_dest == NSX_DEST_ACC)
      |=> o_acc == ($past(o_acc) ^ $past(i_file_rd)))
      else $error("file exclusive OR to accumulator wrong");

   xor_dest_a: assert property (
      (i_valid && i_op == NSX_OP_EXCLUSIVE_OR_ACC_FILE && i_dest == NSX_DEST_FILE)
      |=> o_file_we && o_file_wd == ($past(o_acc) ^ $past(i_file_rd)) && $stable(o_acc)
          && o_file_wa == $past(i_faddr))
      else $error("file exclusive OR not stored to file");

   dir_load_a: assert property (
      (i_valid && i_op == NSX_OP_DIR_LOAD && i_faddr == NSX_DIR_SEL_HI)
      |=> o_dir_b == $past(o_acc) && $stable(o_dir_a) && !o_file_we)
      else $error("direction load failed");

   dir_low_load_a: assert property (
      (i_valid && i_op == NSX_OP_DIR_LOAD && i_faddr == NSX_DIR_SEL_LO)
      |=> o_dir_a == $past(o_acc) && $stable(o_dir_b) && !o_file_we)
      else $error("low direction load failed");

   // A direction load with any other operand is a no-operation.
   dir_ignore_a: assert property (
      (i_valid && i_op == NSX_OP_DIR_LOAD && i_faddr != NSX_DIR_SEL_LO
          && i_faddr != NSX_DIR_SEL_HI)
      |=> $stable(o_dir_a) && $stable(o_dir_b) && $stable(o_acc) && !o_file_we)
      else $error("direction load with bad operand changed state");

   xor_literal_a: assert property (
      (i_valid && i_op == NSX_OP_EXCLUSIVE_OR_LITERAL)
      |=> o_acc == ($past(o_acc) ^ $past(i_lit)) && !o_file_we)
      else $error("literal exclusive OR wrong");

   zero_flag_a: assert property (
      (i_valid && i_op == NSX_OP_EXCLUSIVE_OR_ACC_FILE)
      |=> o_zero == (($past(o_acc) ^ $past(i_file_rd)) == 8'h00))
      else $error("zero flag wrong after file exclusive OR");

   flag_hold_a: assert property (
      (i_valid && (i_op == NSX_OP_NIBBLE_EXCHANGE_FILE || i_op == NSX_OP_DIR_LOAD))
      |=> $stable(o_zero))
      else $error("zero flag changed by swap or direction load");

   // The literal form leaves the flag alone; this is a chosen reading.
   lit_flag_hold_a: assert property (
      (i_valid && i_op == NSX_OP_EXCLUSIVE_OR_LITERAL)
      |=> $stable(o_zero))
      else $error("zero flag changed by literal exclusive OR");

   // An empty slot must not disturb any architectural state.
   idle_hold_a: assert property (
      !i_valid
      |=> $stable(o_acc) && $stable(o_zero) && $stable(o_dir_a) && $stable(o_dir_b)
          && !o_file_we)
      else $error("state changed without an operation");

   swap_seen_c:   cover property (i_valid && i_op == NSX_OP_NIBBLE_EXCHANGE_FILE ##1 o_file_we);
   dirb_seen_c:   cover property (i_valid && i_op == NSX_OP_DIR_LOAD ##1 $changed(o_dir_b));
   zero_seen_c:   cover property ($rose(o_zero));
   dir_seen_c:    cover property (i_valid && i_op == NSX_OP_DIR_LOAD ##1 $changed(o_dir_a));
   lit_seen_c:    cover property (i_valid && i_op == NSX_OP_EXCLUSIVE_OR_LITERAL ##1 $changed(o_acc));
endmodule // nsx_datapath

/* File: dv/nsx_file_model.sv */
/*
 * File register array model standing behind the datapath.
 * Assumes reads are combinational and writes arrive as one-cycle strobes.
 */
`timescale 1ns/1ps
module nsx_file_model (
   input  wire logic       i_clk,  // Clock
   input  wire logic       i_rstn, // Reset, active low
   input  wire logic [4:0] i_ra,   // Read address
   input  wire logic       i_we,   // Write strobe
   input  wire logic [4:0] i_wa,   // Write address
   input  wire logic [7:0] i_wd,   // Write data
   output logic      [7:0] o_rd    // Read data
);
   logic [7:0] mem_q [32];
   assign o_rd = mem_q[i_ra];
   // Distinct contents per address so a wrong address shows as a wrong value.
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         for (int i = 0; i < 32; i++) mem_q[i] <= 8'(i) * 8'h25 + 8'h11;
      end else if (i_we) begin
         mem_q[i_wa] <= i_wd;
      end
   end
endmodule // nsx_file_model

/* File: dv/nsx_datapath_test.sv */
/*
 * Self-checking bench for the datapath with a file array model.
 * Assumes a one-cycle answer to each operation, as handed over.
 */
`timescale 1ns/1ps
module nsx_datapath_test;
   import nsx_pkg::*;
   logic clk = 1'b0, rstn = 1'b0, valid = 1'b0, dest = 1'b0, zero, fwe;
   nsx_op_e op = NSX_OP_NONE;
   logic [4:0] faddr = 5'h00, fwa;
   logic [7:0] lit = 8'h00, frd, acc, fwd, dira, dirb;
   logic [7:0] acc_e = 8'h00, dira_e = 8'hFF, dirb_e = 8'hFF, mem_e [32];
   logic zero_e = 1'b0;
   int fails = 0, cmp_count = 0;
   always #2.5 clk = ~clk;
   nsx_datapath dut (.i_clk(clk), .i_rstn(rstn), .i_valid(valid), .i_op(op),
      .i_faddr(faddr), .i_dest(dest), .i_lit(lit), .i_file_rd(frd), .o_acc(acc),
      .o_zero(zero), .o_file_we(fwe), .o_file_wa(fwa), .o_file_wd(fwd),
      .o_dir_a(dira), .o_dir_b(dirb));
   nsx_file_model files (.i_clk(clk), .i_rstn(rstn), .i_ra(faddr), .i_we(fwe),
      .i_wa(fwa), .i_wd(fwd), .o_rd(frd));
   task automatic check(string n, logic [7:0] s, logic [7:0] e);
      cmp_count++;
      if (s !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   // Presents one operation, predicts its effect and compares every output, the file write address and data only on an expected write.
   task automatic run(nsx_op_e o, logic [4:0] a, logic d, logic [7:0] l, logic v);
      logic [7:0] r;
      logic       we;
      r = 8'h00;
      we = 1'b0;
      @(negedge clk);
      valid = v; op = o; faddr = a; dest = d; lit = l;
      if (v) begin
         case (o)
            NSX_OP_NIBBLE_EXCHANGE_FILE: r = {mem_e[a][3:0], mem_e[a][7:4]};
            NSX_OP_EXCLUSIVE_OR_ACC_FILE: begin
               r = acc_e ^ mem_e[a];
               zero_e = (r == 8'h00);
            end
            NSX_OP_EXCLUSIVE_OR_LITERAL: acc_e = acc_e ^ l;
            NSX_OP_DIR_LOAD: begin
               if (a == NSX_DIR_SEL_LO) dira_e = acc_e;
               if (a == NSX_DIR_SEL_HI) dirb_e = acc_e;
            end
            default: r = 8'h00;
         endcase
         if (o == NSX_OP_NIBBLE_EXCHANGE_FILE || o == NSX_OP_EXCLUSIVE_OR_ACC_FILE) begin
            if (d) begin
               we = 1'b1;
               mem_e[a] = r;
            end else acc_e = r;
         end
      end
      @(negedge clk);
      valid = 1'b0;
      check("acc", acc, acc_e);
      check("zero", {7'h00, zero}, {7'h00, zero_e});
      check("file_we", {7'h00, fwe}, {7'h00, we});
      if (we) check("file_wa", {3'h0, fwa}, {3'h0, a});
      if (we) check("file_wd", fwd, r);
      check("dir_a", dira, dira_e);
      check("dir_b", dirb, dirb_e);
   endtask
   task automatic t_xor;
      run(NSX_OP_EXCLUSIVE_OR_LITERAL, 5'h00, 1'b0, mem_e[3], 1'b1);
      run(NSX_OP_EXCLUSIVE_OR_ACC_FILE, 5'h03, 1'b1, 8'h00, 1'b1);
      run(NSX_OP_EXCLUSIVE_OR_ACC_FILE, 5'h1F, 1'b0, 8'h00, 1'b1);
      run(NSX_OP_EXCLUSIVE_OR_LITERAL, 5'h00, 1'b0, 8'hFF, 1'b1);
      $display("Test xor done");
   endtask
   task automatic t_swap;
      run(NSX_OP_NIBBLE_EXCHANGE_FILE, 5'h09, 1'b0, 8'h00, 1'b1);
      run(NSX_OP_NIBBLE_EXCHANGE_FILE, 5'h09, 1'b1, 8'h00, 1'b1);
      run(NSX_OP_EXCLUSIVE_OR_ACC_FILE, 5'h09, 1'b0, 8'h00, 1'b1);
      $display("Test swap done");
   endtask
   task automatic t_dir;
      run(NSX_OP_EXCLUSIVE_OR_LITERAL, 5'h00, 1'b0, 8'h3C, 1'b1);
      run(NSX_OP_DIR_LOAD, 5'h06, 1'b0, 8'h00, 1'b1);
      run(NSX_OP_DIR_LOAD, 5'h05, 1'b0, 8'h00, 1'b1);
      run(NSX_OP_EXCLUSIVE_OR_LITERAL, 5'h00, 1'b0, 8'hA5, 1'b1);
      run(NSX_OP_DIR_LOAD, 5'h07, 1'b0, 8'h00, 1'b1);
      run(NSX_OP_EXCLUSIVE_OR_LITERAL, 5'h00, 1'b0, 8'h77, 1'b0);
      $display("Test direction and idle done");
   endtask
   // A reset in mid-run must restore every output but the file write address and data; the file array restarts too.
   task automatic t_reset;
      @(negedge clk);
      rstn = 1'b0;
      @(negedge clk);
      check("reset acc", acc, NSX_ACC_RST);
      check("reset zero", {7'h00, zero}, {7'h00, NSX_ZERO_RST});
      check("reset file_we", {7'h00, fwe}, 8'h00);
      check("reset dir_a", dira, NSX_DIR_RST);
      check("reset dir_b", dirb, NSX_DIR_RST);
      rstn = 1'b1;
      acc_e = NSX_ACC_RST;
      zero_e = NSX_ZERO_RST;
      dira_e = NSX_DIR_RST;
      dirb_e = NSX_DIR_RST;
      for (int i = 0; i < 32; i++) mem_e[i] = 8'(i) * 8'h25 + 8'h11;
      run(NSX_OP_EXCLUSIVE_OR_ACC_FILE, 5'h02, 1'b0, 8'h00, 1'b1);
      $display("Test reset done");
   endtask
   task automatic final_report;
      $display("Comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      for (int i = 0; i < 32; i++) mem_e[i] = 8'(i) * 8'h25 + 8'h11;
      repeat (6) @(negedge clk);
      rstn = 1'b1;
      check("reset dir_a", dira, NSX_DIR_RST);
      check("reset acc", acc, NSX_ACC_RST);
      t_xor();
      t_swap();
      t_dir();
      t_reset();
      final_report();
   end
endmodule // nsx_datapath_test
